// ### dv/mcd_host_model.sv
// Host side model: APB master that sends command frames to the decoder.
// Assumes an APB slave on the same clock, any number of wait states.
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_host_model
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic err;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        err     = 1'b0;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data shows garbage, never a stale copy
        pwdata  <= ~d;
    endtask

    // Bias spoils the checksum on purpose
    task automatic send_frame(input logic [7:0] adr, input logic [7:0] ins,
                              input logic [7:0] typ, input logic [31:0] val,
                              input logic [7:0] bias);
        logic [7:0]  fb [9];
        logic [31:0] r;
        fb = '{adr, ins, typ, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0],
               8'h00};
        for (int i = 0; i < 8; i++)
            fb[8] = fb[8] + fb[i];
        fb[8] = fb[8] + bias;
        for (int i = 0; i < 9; i++)
            apb(1'b1, `MCD_ADDR_FRAME, {24'h000000, fb[i]}, r);
    endtask
endmodule // mcd_host_model

// ### dv/motion_command_decoder_bench.sv
// Self-checking bench for the motion command decoder.
// Assumes the host model drives APB; bench drives actual position.
`timescale 1ns/1ps
`include "mcd_params.svh"

module motion_command_decoder_bench
    import mcd_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] actual_pos;
    logic        pos_mode;
    logic        move_dir;
    logic        move_start;
    logic [31:0] target_vel;
    logic [31:0] target_pos;
    logic [31:0] max_pos_speed;
    logic [31:0] ramp_accel;
    logic [31:0] rd;
    int          bad_count;
    int          checked;

    always #20 pclk = ~pclk;

    mcd_decoder mcd_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .actual_pos(actual_pos),
        .pos_mode(pos_mode), .move_dir(move_dir), .move_start(move_start),
        .target_vel(target_vel), .target_pos(target_pos),
        .max_pos_speed(max_pos_speed), .ramp_accel(ramp_accel));

    mcd_host_model mcd_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        mcd_host_model_inst.apb(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        mcd_host_model_inst.apb(1'b0, a, 32'h00000000, rd);
        check(rd & m, e);
    endtask

    task automatic fr(input logic [7:0] ins, input logic [7:0] typ, input logic [31:0] v);
        mcd_host_model_inst.send_frame(`MCD_MOD_ADDR, ins, typ, v, 8'h00);
    endtask

    // Reading the reply also clears reply-valid for the next scenario
    task automatic rep(input logic [7:0] code, input logic [31:0] v);
        rdc(`MCD_ADDR_STATUS, 32'h0000ff01, {16'h0000, code, 8'h01});
        rdc(`MCD_ADDR_REPLY, 32'hffffffff, v);
    endtask

    task automatic t_reset();
        @(posedge pclk);
        #1;
        check({29'h0, pos_mode, move_dir, move_start}, 32'h00000002);
        check(target_vel | target_pos, 32'h00000000);
        rdc(`MCD_ADDR_PDATA, 32'hffffffff, 32'h00000000);
    endtask

    task automatic t_spin();
        fr(`MCD_CMD_SPIN_CW, 8'h00, 32'h000003e8);
        rep(`MCD_ST_OK, 32'h000003e8);
        check(target_vel, 32'h000003e8);
        check({30'h0, pos_mode, move_dir}, 32'h00000001);
        fr(`MCD_CMD_SPIN_CCW, 8'h00, 32'h000007ff);
        rep(`MCD_ST_OK, 32'h000007ff);
        check(target_vel, 32'hfffff801);
        check({30'h0, pos_mode, move_dir}, 32'h00000000);
        fr(`MCD_CMD_SPIN_CW, 8'h00, 32'h00000800);
        rep(`MCD_ST_BAD_VAL, 32'h00000000);
        check(target_vel, 32'hfffff801);
        fr(`MCD_CMD_PWRITE, 8'h02, 32'h00000800);
        rep(`MCD_ST_BAD_VAL, 32'h00000000);
        check(target_vel, 32'hfffff801);
        fr(`MCD_CMD_SPIN_CW, 8'h01, 32'h00000005);
        rep(`MCD_ST_BAD_TYPE, 32'h00000000);
    endtask

    task automatic t_goto();
        fr(`MCD_CMD_PWRITE, 8'h04, 32'h000003e8);
        rep(`MCD_ST_OK, 32'h000003e8);
        check(max_pos_speed, 32'h000003e8);
        fr(`MCD_CMD_PWRITE, 8'h05, 32'h0000004d);
        // Parameters land one edge after the ninth byte
        repeat (2) @(posedge pclk);
        check(ramp_accel, 32'h0000004d);
        wr(`MCD_ADDR_PSEL, 32'h00000004);
        rdc(`MCD_ADDR_PDATA, 32'hffffffff, 32'h000003e8);
        fr(`MCD_CMD_GOTO, 8'h00, 32'h00015f90);
        @(posedge pclk);
        #1;
        check({31'h0, move_start}, 32'h00000001);
        rep(`MCD_ST_OK, 32'h00015f90);
        check(target_pos, 32'h00015f90);
        check({30'h0, pos_mode, move_dir}, 32'h00000003);
        actual_pos <= 32'h00001388;
        fr(`MCD_CMD_GOTO, 8'h01, 32'hffffd8f0);
        rep(`MCD_ST_OK, 32'hffffd8f0);
        check(target_pos, 32'hffffec78);
        check({30'h0, pos_mode, move_dir}, 32'h00000002);
        wr(`MCD_ADDR_CSEL, 32'h00000008);
        wr(`MCD_ADDR_CDATA, 32'h12345678);
        fr(`MCD_CMD_GOTO, 8'h02, 32'h00000008);
        repeat (2) @(posedge pclk);
        check(target_pos, 32'h12345678);
        fr(`MCD_CMD_GOTO, 8'h02, 32'h00000015);
        rep(`MCD_ST_BAD_VAL, 32'h00000000);
        fr(`MCD_CMD_GOTO, 8'h03, 32'h00000000);
        rep(`MCD_ST_BAD_TYPE, 32'h00000000);
        // Signed compare would say backward; wrapped difference says forward
        actual_pos <= 32'h7fff0000;
        fr(`MCD_CMD_GOTO, 8'h00, 32'h80000010);
        rep(`MCD_ST_OK, 32'h80000010);
        check({target_pos[31:1], move_dir}, 32'h80000011);
    endtask

    task automatic t_abort();
        fr(`MCD_CMD_HALT, 8'h00, 32'h00000000);
        rep(`MCD_ST_OK, 32'h00000000);
        check(target_vel, 32'h00000000);
        check({30'h0, pos_mode, move_dir}, 32'h00000001);
        fr(`MCD_CMD_GOTO, 8'h00, 32'h00000064);
        fr(`MCD_CMD_SPIN_CCW, 8'h00, 32'h0000000a);
        rep(`MCD_ST_OK, 32'h0000000a);
        check(target_vel, 32'hfffffff6);
        check({31'h0, pos_mode}, 32'h00000000);
    endtask

    task automatic t_refuse();
        mcd_host_model_inst.send_frame(8'h01, `MCD_CMD_SPIN_CW, 8'h00, 32'h000001f4, 8'h01);
        rep(`MCD_ST_CHKSUM, 32'h00000000);
        check(target_vel, 32'hfffffff6);
        mcd_host_model_inst.send_frame(8'h02, `MCD_CMD_SPIN_CW, 8'h00, 32'h000001f4, 8'h00);
        rdc(`MCD_ADDR_STATUS, 32'h00000001, 32'h00000000);
        check(target_vel, 32'hfffffff6);
        fr(8'h09, 8'h00, 32'h00000000);
        rep(`MCD_ST_BAD_CMD, 32'h00000000);
        // Partial frame left behind, then flushed so the next one lines up
        wr(`MCD_ADDR_FRAME, 32'h00000001);
        wr(`MCD_ADDR_FRAME, 32'h00000003);
        wr(`MCD_ADDR_STATUS, 32'h00000001);
        fr(`MCD_CMD_HALT, 8'h00, 32'h00000000);
        rep(`MCD_ST_OK, 32'h00000000);
        check(target_vel, 32'h00000000);
        rdc(12'h0fc, 32'hffffffff, 32'h00000000);
        check({31'h0, mcd_host_model_inst.err}, 32'h00000001);
    endtask

    initial
    begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        actual_pos = 32'h00000000;
        bad_count  = 0;
        checked    = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_spin();
        t_goto();
        t_abort();
        t_refuse();
        wrap_up();
    end

    // About 700 cycles of traffic; nearly thirty times that means a hang
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
endmodule // motion_command_decoder_bench

// ### hw/mcd_decoder.sv
// Motion command decoder for one stepper axis, APB slave.
// Assumes a ramp generator outside that follows the target outputs.
//
// Behaviour
// - Spin clockwise drives the axis toward increasing position.
// - Spin counter-clockwise drives the axis toward decreasing position.
// - Spin commands select velocity mode, load signed velocity into parameter 2.
// - Goto replies OK at once after set-up, not after the move.
// - New commands are taken while a positioning move runs.
// - Halt selects velocity mode and zeroes target velocity for a ramped stop.
// - Goto type byte: 0 fixed, 1 offset, 2 stored point.
// - Goto selects position mode and writes target position parameter 0.
// - Targets and offsets are 32-bit signed values.
// - Offset goto adds signed offset to actual position.
// - Overflowing distance moves the way the wrapped difference points.
// - Halt or spin abandons a positioning move in progress.
// - Moves use ramp and speed held in the axis parameters.
// - Frame: address, instruction, type, bank, four value bytes, checksum.
// - Negative values travel in two's complement.
// - Axis parameters are volatile, cleared at reset.
// - Parameter write stores the value in the parameter named by type.
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_decoder
    import mcd_pkg::*;
#(
    parameter logic [7:0] MOD_ADDR  = `MCD_MOD_ADDR,
    parameter int         N_POINT   = `MCD_N_POINT,
    parameter logic [3:0] ACCEL_IDX = `MCD_PARAM_ACCEL
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] actual_pos,
    output logic             pos_mode,
    output logic             move_dir,
    output logic             move_start,
    output logic      [31:0] target_vel,
    output logic      [31:0] target_pos,
    output logic      [31:0] max_pos_speed,
    output logic      [31:0] ramp_accel
);
    localparam int CW = $clog2(N_POINT);

    function automatic logic wrap_fwd(input logic [31:0] tgt, input logic [31:0] act);
        logic [31:0] diff;
        diff = tgt - act;
        return ~diff[31];
    endfunction

    logic              rx_valid;
    logic              rx_err;
    logic [7:0]        rx_instr;
    logic [7:0]        rx_type;
    logic [7:0]        rx_bank;
    logic [31:0]       rx_value;

    logic [31:0]       param_ff [`MCD_NPARAM_N];
    logic [31:0]       point_ff [N_POINT];
    logic [3:0]        psel_ff;
    logic [CW-1:0]     csel_ff;
    mcd_mode_type      mode_ff;
    mcd_mode_type      nxt_mode;
    logic              dir_ff;
    logic              nxt_dir;
    logic              start_ff;
    logic              reply_valid_ff;
    logic [7:0]        reply_status_ff;
    logic [7:0]        last_instr_ff;
    logic [31:0]       reply_value_ff;
    logic [31:0]       prdata_ff;
    logic [31:0]       rd_mux;
    logic [31:0]       status_word;

    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire setup    = psel & ~penable;

    wire hit_frame  = paddr == `MCD_ADDR_FRAME;
    wire hit_status = paddr == `MCD_ADDR_STATUS;
    wire hit_reply  = paddr == `MCD_ADDR_REPLY;
    wire hit_tvel   = paddr == `MCD_ADDR_TVEL;
    wire hit_tpos   = paddr == `MCD_ADDR_TPOS;
    wire hit_psel   = paddr == `MCD_ADDR_PSEL;
    wire hit_pdata  = paddr == `MCD_ADDR_PDATA;
    wire hit_csel   = paddr == `MCD_ADDR_CSEL;
    wire hit_cdata  = paddr == `MCD_ADDR_CDATA;
    wire addr_hit   = hit_frame | hit_status | hit_reply | hit_tvel | hit_tpos
                    | hit_psel | hit_pdata | hit_csel | hit_cdata;

    assign pready  = 1'b1;
    assign pslverr = acc & ~addr_hit;

    mcd_frame_rx #(
        .MOD_ADDR    (MOD_ADDR)
    ) u_rx (
        .pclk        (pclk),
        .presetn     (presetn),
        .byte_valid  (wr & hit_frame),
        .byte_data   (pwdata[7:0]),
        .flush       (wr & hit_status & pwdata[`MCD_SB_FLUSH]),
        .frame_valid (rx_valid),
        .frame_err   (rx_err),
        .instr       (rx_instr),
        .type_b      (rx_type),
        .bank        (rx_bank),
        .value       (rx_value)
    );

    // Command decode
    wire is_cw    = rx_instr == `MCD_CMD_SPIN_CW;
    wire is_ccw   = rx_instr == `MCD_CMD_SPIN_CCW;
    wire is_halt  = rx_instr == `MCD_CMD_HALT;
    wire is_goto  = rx_instr == `MCD_CMD_GOTO;
    wire is_pwr   = rx_instr == `MCD_CMD_PWRITE;
    wire is_spin  = is_cw | is_ccw;
    wire is_vcmd  = is_spin | is_halt;
    wire known    = is_vcmd | is_goto | is_pwr;
    wire t_fixed  = rx_type == `MCD_TYPE_FIXED;
    wire t_offset = rx_type == `MCD_TYPE_OFFSET;
    wire t_stored = rx_type == `MCD_TYPE_STORED;

    wire signed [31:0] val_s = $signed(rx_value);
    wire vel_ok   = (val_s <= $signed(`MCD_VEL_MAX))
                 && (val_s >= -$signed(`MCD_VEL_MAX));
    wire point_ok = rx_value < N_POINT;

    wire [7:0] exec_status =
        rx_err                                    ? `MCD_ST_CHKSUM   :
        !known                                    ? `MCD_ST_BAD_CMD  :
        (is_vcmd && !t_fixed)                     ? `MCD_ST_BAD_TYPE :
        (is_goto && !(t_fixed|t_offset|t_stored)) ? `MCD_ST_BAD_TYPE :
        (is_pwr && rx_type >= `MCD_NPARAM)        ? `MCD_ST_BAD_TYPE :
        (is_spin && !vel_ok)                      ? `MCD_ST_BAD_VAL  :
        // Velocity bound also holds for a direct parameter write
        (is_pwr && rx_type[3:0] == `MCD_PARAM_TVEL
                && !vel_ok)                       ? `MCD_ST_BAD_VAL  :
        (is_goto && t_stored && !point_ok)        ? `MCD_ST_BAD_VAL  :
                                                    `MCD_ST_OK;

    // No busy term: intake never waits on a move
    wire apply   = rx_valid && exec_status == `MCD_ST_OK;
    wire go_pos  = apply & is_goto;
    wire go_vel  = apply & is_vcmd;

    // Offset sum wraps in 32 bits; staying in range is the host's job
    wire [31:0] goto_tgt =
        t_offset ? actual_pos + rx_value :
        t_stored ? point_ff[rx_value[CW-1:0]] :
                   rx_value;

    wire [31:0] spin_vel =
        is_cw  ? rx_value :
        is_ccw ? 32'h0000_0000 - rx_value :
                 32'h0000_0000;

    wire        pw_en  = go_pos | go_vel | (apply & is_pwr);
    wire [3:0]  pw_idx = is_goto ? `MCD_PARAM_TPOS :
                         is_pwr  ? rx_type[3:0] :
                                   `MCD_PARAM_TVEL;
    wire [31:0] pw_val = is_goto ? goto_tgt :
                         is_pwr  ? rx_value : spin_vel;

    // Plain flops, no retention: values lost with power
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `MCD_NPARAM_N; i++)
                param_ff[i] <= 32'h0000_0000;
        end
        else if (pw_en)
            param_ff[pw_idx] <= pw_val;
    end

    // Stored points stand in for the point save commands
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < N_POINT; i++)
                point_ff[i] <= 32'h0000_0000;
        end
        else if (wr && hit_cdata && csel_ff < N_POINT)
            point_ff[csel_ff] <= pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psel_ff <= 4'h0;
            csel_ff <= '0;
        end
        else
        begin
            if (wr && hit_psel)
                psel_ff <= pwdata[3:0];
            if (wr && hit_csel)
                csel_ff <= pwdata[CW-1:0];
        end
    end

    always_comb
    begin
        nxt_mode = mode_ff;
        case (mode_ff)
            mcd_mode_vel:
                if (go_pos)
                    nxt_mode = mcd_mode_pos;
            mcd_mode_pos:
                if (go_vel)
                    nxt_mode = mcd_mode_vel;
            default:
                nxt_mode = mcd_mode_vel;
        endcase
    end

    // Wrapped difference picks the shorter modular path
    assign nxt_dir = go_pos             ? wrap_fwd(goto_tgt, actual_pos) :
                     (apply && is_cw)   ? 1'b1 :
                     (apply && is_ccw)  ? 1'b0 : dir_ff;

    wire reply_set = rx_valid | rx_err;
    wire reply_clr = rd & hit_reply;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_ff  <= mcd_mode_vel;
            dir_ff   <= 1'b1;
            start_ff <= 1'b0;
        end
        else
        begin
            mode_ff  <= nxt_mode;
            dir_ff   <= nxt_dir;
            start_ff <= go_pos;
        end
    end

    // Reply follows set-up at once; set beats a same-cycle read clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reply_valid_ff  <= 1'b0;
            reply_status_ff <= 8'h00;
            last_instr_ff   <= 8'h00;
            reply_value_ff  <= 32'h0000_0000;
        end
        else
        begin
            reply_valid_ff <= reply_set | (reply_valid_ff & ~reply_clr);
            if (reply_set)
            begin
                reply_status_ff <= exec_status;
                last_instr_ff   <= rx_instr;
                reply_value_ff  <= apply ? rx_value : 32'h0000_0000;
            end
        end
    end

    always_comb
    begin
        status_word                 = 32'h0000_0000;
        status_word[`MCD_SB_VALID]  = reply_valid_ff;
        status_word[`MCD_SB_VEL]    = mode_ff == mcd_mode_vel;
        status_word[`MCD_SB_POS]    = mode_ff == mcd_mode_pos;
        status_word[`MCD_SB_CODE]   = reply_status_ff;
        status_word[`MCD_SB_INSTR]  = last_instr_ff;
    end

    always_comb
    begin
        if (hit_status)
            rd_mux = status_word;
        else if (hit_reply)
            rd_mux = reply_value_ff;
        else if (hit_tvel)
            rd_mux = param_ff[`MCD_PARAM_TVEL];
        else if (hit_tpos)
            rd_mux = param_ff[`MCD_PARAM_TPOS];
        else if (hit_psel)
            rd_mux = {28'h0000000, psel_ff};
        else if (hit_pdata)
            rd_mux = param_ff[psel_ff];
        else if (hit_csel)
            rd_mux = 32'(csel_ff);
        else if (hit_cdata)
            rd_mux = (csel_ff < N_POINT) ? point_ff[csel_ff] : 32'h0000_0000;
        else
            rd_mux = 32'h0000_0000;
    end

    // Captured in setup so the zero-wait access sees a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (setup)
            prdata_ff <= rd_mux;
    end

    assign prdata        = prdata_ff;
    assign pos_mode      = mode_ff == mcd_mode_pos;
    assign move_dir      = dir_ff;
    assign move_start    = start_ff;
    assign target_vel    = param_ff[`MCD_PARAM_TVEL];
    assign target_pos    = param_ff[`MCD_PARAM_TPOS];
    assign max_pos_speed = param_ff[`MCD_PARAM_MAXSPD];
    assign ramp_accel    = param_ff[ACCEL_IDX];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence pos_move_s;
        mode_ff == mcd_mode_pos;
    endsequence

    sequence vel_cmd_s;
        apply && is_vcmd;
    endsequence

    spin_cw_dir_a: assert property (
        apply && is_cw |=> move_dir && !pos_mode && target_vel == $past(rx_value))
        else $error("clockwise spin not applied");

    spin_ccw_dir_a: assert property (
        apply && is_ccw |=> !move_dir && target_vel == 32'h0 - $past(rx_value))
        else $error("counter-clockwise spin not applied");

    vel_range_a: assert property (
        !pos_mode |-> $signed(target_vel) <= $signed(`MCD_VEL_MAX)
                   && $signed(target_vel) >= -$signed(`MCD_VEL_MAX))
        else $error("velocity target out of range");

    goto_reply_a: assert property (
        go_pos |=> reply_valid_ff && reply_status_ff == `MCD_ST_OK && move_start)
        else $error("goto reply late or wrong");

    halt_zero_a: assert property (
        apply && is_halt |=> target_vel == 32'h0 && !pos_mode)
        else $error("halt did not zero velocity");

    goto_fixed_a: assert property (
        go_pos && t_fixed |=> pos_mode && target_pos == $past(rx_value))
        else $error("fixed goto target wrong");

    offset_sum_a: assert property (
        go_pos && t_offset |=> target_pos == $past(actual_pos) + $past(rx_value))
        else $error("offset goto target wrong");

    wrap_dir_a: assert property (
        move_start |-> move_dir == wrap_fwd(target_pos, $past(actual_pos)))
        else $error("move direction wrong");

    move_abort_a: assert property (
        pos_move_s ##0 vel_cmd_s |=> !pos_mode)
        else $error("move not abandoned");

    param_write_a: assert property (
        apply && is_pwr |=> param_ff[$past(rx_type[3:0])] == $past(rx_value))
        else $error("parameter write lost");

endmodule // mcd_decoder

// ### hw/mcd_frame_rx.sv
// Frame assembler: nine bytes in, checked fields out.
// Assumes one byte per strobe, host keeps frames in step.
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_frame_rx
    import mcd_pkg::*;
#(
    parameter logic [7:0] MOD_ADDR = `MCD_MOD_ADDR
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic        flush,
    output logic             frame_valid,
    output logic             frame_err,
    output logic [7:0]       instr,
    output logic [7:0]       type_b,
    output logic [7:0]       bank,
    output logic [31:0]      value
);
    logic [3:0] cnt_ff;
    logic [7:0] sum_ff;
    logic [7:0] buf_ff [`MCD_HDR_LEN];
    logic       last;
    logic       sum_ok;
    logic       addr_ok;

    assign last    = byte_valid & (cnt_ff == `MCD_LAST_IDX);
    assign sum_ok  = byte_data == sum_ff;
    assign addr_ok = buf_ff[0] == MOD_ADDR;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 4'h0;
            sum_ff <= 8'h00;
        end
        else if (flush || last)
        begin
            cnt_ff <= 4'h0;
            sum_ff <= 8'h00;
        end
        else if (byte_valid)
        begin
            cnt_ff <= cnt_ff + 4'h1;
            sum_ff <= sum_ff + byte_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `MCD_HDR_LEN; i++)
                buf_ff[i] <= 8'h00;
        end
        else if (byte_valid && !last && !flush)
            buf_ff[cnt_ff[2:0]] <= byte_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_valid <= 1'b0;
            frame_err   <= 1'b0;
            instr       <= 8'h00;
            type_b      <= 8'h00;
            bank        <= 8'h00;
            value       <= 32'h0000_0000;
        end
        else
        begin
            // Foreign address: frame dropped with no reply
            frame_valid <= last & sum_ok & addr_ok & ~flush;
            frame_err   <= last & ~sum_ok & addr_ok & ~flush;
            if (last)
            begin
                instr  <= buf_ff[1];
                type_b <= buf_ff[2];
                bank   <= buf_ff[3];
                // Most significant first, two's complement kept as sent
                value  <= {buf_ff[4], buf_ff[5], buf_ff[6], buf_ff[7]};
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    frame_len_a: assert property (
        frame_valid |-> $past(byte_valid) && $past(cnt_ff) == `MCD_LAST_IDX)
        else $error("frame accepted without ninth byte");

    chk_reject_a: assert property (
        (last && !sum_ok) |=> !frame_valid)
        else $error("frame with bad checksum accepted");

endmodule // mcd_frame_rx

// ### hw/mcd_params.svh
// Constants of the motion command decoder: offsets, codes, fields.
// Assumes inclusion by bare name, design and bench files alike.
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

`define MCD_ADDR_FRAME   12'h000
`define MCD_ADDR_STATUS  12'h004
`define MCD_ADDR_REPLY   12'h008
`define MCD_ADDR_TVEL    12'h00c
`define MCD_ADDR_TPOS    12'h010
`define MCD_ADDR_PSEL    12'h014
`define MCD_ADDR_PDATA   12'h018
`define MCD_ADDR_CSEL    12'h01c
`define MCD_ADDR_CDATA   12'h020

`define MCD_CMD_SPIN_CW  8'h01
`define MCD_CMD_SPIN_CCW 8'h02
`define MCD_CMD_HALT     8'h03
`define MCD_CMD_GOTO     8'h04
`define MCD_CMD_PWRITE   8'h05

`define MCD_TYPE_FIXED   8'h00
`define MCD_TYPE_OFFSET  8'h01
`define MCD_TYPE_STORED  8'h02

`define MCD_NPARAM       8'h10
`define MCD_NPARAM_N     16
`define MCD_PARAM_TPOS   4'h0
`define MCD_PARAM_TVEL   4'h2
`define MCD_PARAM_MAXSPD 4'h4
`define MCD_PARAM_ACCEL  4'h5

`define MCD_ST_OK        8'h64
`define MCD_ST_CHKSUM    8'h01
`define MCD_ST_BAD_CMD   8'h02
`define MCD_ST_BAD_TYPE  8'h03
`define MCD_ST_BAD_VAL   8'h04

`define MCD_VEL_MAX      32'h000007ff
`define MCD_MOD_ADDR     8'h01
`define MCD_HDR_LEN      8
`define MCD_LAST_IDX     4'h8
`define MCD_N_POINT      21

`define MCD_SB_VALID     0
`define MCD_SB_VEL       1
`define MCD_SB_POS       2
`define MCD_SB_CODE      15:8
`define MCD_SB_INSTR     23:16
`define MCD_SB_FLUSH     0

`endif

// ### hw/mcd_pkg.sv
// Types shared by the motion command decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package mcd_pkg;
    typedef enum logic [1:0]
    {
        mcd_mode_vel = 2'b01,
        mcd_mode_pos = 2'b10
    } mcd_mode_type;
endpackage
